/* src/isf_status_flags.sv */
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "isf_defs.svh"
module isf_status_flags import isf_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scl_in,
  input wire logic start_det,
  input wire logic stop_det,
  input wire logic slave_tx_active,
  input wire logic receiver_mode,
  input wire logic nack_driven,
  input wire logic rx_bit_valid,
  input wire logic rx_bit,
  output logic start_request,
  output logic repeated_start,
  output logic peripheral_run,
  output logic loopback_mode,
  output logic irq
);
  // ****************************************
  // bus slave
  // ****************************************
  isf_reg_if regs();

  isf_axil_slave u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .regs(regs)
  );

  // ****************************************
  // register decode
  // ****************************************
  logic wr_status, wr_mask, wr_mode, rd_rxdata;
  logic hi_lane, lo_lane;
  logic slave_tx_direction_flag_clr, nack_clr, bb_clr;

  assign hi_lane = regs.wr_strb[1];
  assign lo_lane = regs.wr_strb[0];
  assign wr_status = regs.wr_en && (regs.wr_addr == `ISF_OFS_STATUS);
  assign wr_mask = regs.wr_en && (regs.wr_addr == `ISF_OFS_MASK);
  assign wr_mode = regs.wr_en && (regs.wr_addr == `ISF_OFS_MODE);
  assign rd_rxdata = regs.rd_en && (regs.rd_addr == `ISF_OFS_RXDATA);
  // clears act only on a one in an enabled lane; zeros change nothing
  assign slave_tx_direction_flag_clr = wr_status && hi_lane
    && regs.wr_data[`ISF_SLAVE_TX_DIRECTION_FLAG_BIT]; // [R5] [R17]
  assign nack_clr = wr_status && hi_lane
    && regs.wr_data[`ISF_NACK_BIT]; // [R7] [R17]
  assign bb_clr = wr_status && hi_lane
    && regs.wr_data[`ISF_BB_BIT]; // [R12] [R17]

  always_comb begin
    regs.wr_err = !(regs.wr_addr == `ISF_OFS_STATUS
      || regs.wr_addr == `ISF_OFS_MASK
      || regs.wr_addr == `ISF_OFS_MODE);
  end

  // ****************************************
  // mode and mask registers
  // ****************************************
  isf_word_type mask, next_mask;
  logic start_request_bit, next_stt, next_run, next_dlb;
  localparam isf_word_type mode_rst_word = `ISF_MODE_RST;

  always_comb begin
    next_mask = mask;
    next_run = peripheral_run;
    next_dlb = loopback_mode;
    next_stt = start_request_bit;
    if (wr_mask && lo_lane) begin
      next_mask[7:0] = regs.wr_data[7:0];
    end
    if (wr_mask && hi_lane) begin
      next_mask[15:8] = regs.wr_data[15:8];
    end
    if (start_det) begin
      next_stt = 1'b0;
    end
    if (wr_mode && lo_lane) begin
      next_run = regs.wr_data[`ISF_RUN_BIT];
      next_dlb = regs.wr_data[`ISF_DLB_BIT];
    end
    if (wr_mode && hi_lane && regs.wr_data[`ISF_STT_BIT]) begin
      next_stt = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= `ISF_MASK_RST;
      peripheral_run <= mode_rst_word[`ISF_RUN_BIT];
      loopback_mode <= mode_rst_word[`ISF_DLB_BIT];
      start_request_bit <= mode_rst_word[`ISF_STT_BIT];
    end else begin
      mask <= next_mask;
      peripheral_run <= next_run;
      loopback_mode <= next_dlb;
      start_request_bit <= next_stt;
    end
  end

  assign start_request = start_request_bit;
  // a request made while the bus is held becomes a restart
  assign repeated_start = start_request_bit && bb; // [R13]

  // ****************************************
  // status flags
  // ****************************************
  logic slave_tx_direction_flag, nack, bb, ovr, prst, nack_set, bb_set;
  logic next_slave_tx_direction_flag, next_nack, next_bb;
  logic [7:0] rx_data;

  // run low is the peripheral reset
  assign prst = !peripheral_run;
  assign nack_set = nack_driven && receiver_mode; // [R6]
  // with run low nobody drives the clock; held low still means busy
  assign bb_set = start_det || (prst && !scl_in); // [R9] [R10]

  always_comb begin
    next_slave_tx_direction_flag = slave_tx_direction_flag;
    if (start_det || stop_det || slave_tx_direction_flag_clr) begin
      next_slave_tx_direction_flag = 1'b0; // [R4] [R5]
    end
    if (slave_tx_active) begin
      next_slave_tx_direction_flag = 1'b1; // [R3] [R18]
    end
    if (loopback_mode) begin
      next_slave_tx_direction_flag = 1'b0; // [R2]
    end
  end

  always_comb begin
    next_nack = nack;
    if (nack_clr || prst) begin
      next_nack = 1'b0; // [R7] [R8]
    end
    if (nack_set) begin
      next_nack = 1'b1; // [R6] [R18]
    end
  end

  always_comb begin
    next_bb = bb;
    if (stop_det || bb_clr || prst) begin
      next_bb = 1'b0; // [R11] [R12] [R8]
    end
    if (bb_set) begin
      next_bb = 1'b1; // [R9] [R10] [R18]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slave_tx_direction_flag <= `ISF_FLAG_RST;
      nack <= `ISF_FLAG_RST;
      bb <= `ISF_FLAG_RST;
    end else begin
      slave_tx_direction_flag <= next_slave_tx_direction_flag;
      nack <= next_nack;
      bb <= next_bb;
    end
  end

  isf_rx_path u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(prst),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .data_read(rd_rxdata),
    .rx_data(rx_data),
    .overrun(ovr)
  );

  // ****************************************
  // read mux and interrupt
  // ****************************************
  isf_word_type status_word, mode_word;

  always_comb begin
    status_word = 16'h0000; // [R1]
    status_word[`ISF_SLAVE_TX_DIRECTION_FLAG_BIT] = slave_tx_direction_flag;
    status_word[`ISF_NACK_BIT] = nack;
    status_word[`ISF_BB_BIT] = bb;
    status_word[`ISF_OVR_BIT] = ovr;
    mode_word = 16'h0000;
    mode_word[`ISF_RUN_BIT] = peripheral_run;
    mode_word[`ISF_DLB_BIT] = loopback_mode;
    mode_word[`ISF_STT_BIT] = start_request_bit;
  end

  always_comb begin
    regs.rd_err = 1'b0;
    regs.rd_data = 32'h0000_0000;
    unique case (regs.rd_addr)
      `ISF_OFS_STATUS: regs.rd_data = {16'h0000, status_word};
      `ISF_OFS_MASK: regs.rd_data = {16'h0000, mask};
      `ISF_OFS_MODE: regs.rd_data = {16'h0000, mode_word};
      `ISF_OFS_RXDATA: regs.rd_data = {24'h00_0000, rx_data};
      default: regs.rd_err = 1'b1;
    endcase
  end

  // level output: stays high until the flag is cleared or masked
  assign irq = |(status_word & mask);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_slave_tx_direction_flag_then_edge;
    (slave_tx_active && !loopback_mode)
      ##1 ((start_det || stop_det) && !slave_tx_active);
  endsequence

  sequence s_zero_write_bb;
    bb ##0 (wr_status && regs.wr_data[15:11] == 5'h00);
  endsequence

  AST_RSVD: assert property ( // [R1]
    regs.rd_addr == `ISF_OFS_STATUS |-> !regs.rd_data[15])
    else $error("reserved status bit reads one");
  AST_DLB: assert property ( // [R2]
    loopback_mode |=> !slave_tx_direction_flag)
    else $error("direction flag set in loopback");
  AST_SLAVE_TX_DIRECTION_FLAG_SET: assert property ( // [R3]
    slave_tx_active && !loopback_mode |=> slave_tx_direction_flag)
    else $error("direction flag missed slave transmit");
  AST_SLAVE_TX_DIRECTION_FLAG_EDGE: assert property ( // [R4]
    s_slave_tx_direction_flag_then_edge |=> !slave_tx_direction_flag)
    else $error("direction flag not cleared by start or stop");
  AST_SLAVE_TX_DIRECTION_FLAG_W1C: assert property ( // [R5]
    slave_tx_direction_flag && slave_tx_direction_flag_clr && !slave_tx_active |=> !slave_tx_direction_flag)
    else $error("direction flag not cleared by write");
  AST_NACK_SET: assert property ( // [R6]
    nack_driven && receiver_mode |=> nack)
    else $error("nack flag not set");
  AST_NACK_W1C: assert property ( // [R7]
    nack_clr && !nack_set |=> !nack)
    else $error("nack flag not cleared by write");
  AST_PRST: assert property ( // [R8]
    prst && scl_in && !start_det && !nack_set |=> !nack && !bb)
    else $error("flags survive peripheral reset");
  AST_BB_START: assert property ( // [R9]
    start_det |=> bb)
    else $error("busy not set by start");
  AST_BB_SCL: assert property ( // [R10]
    (prst && !scl_in) [*2] |-> bb ##1 bb)
    else $error("busy not held with clock low");
  AST_BB_STOP: assert property ( // [R11]
    stop_det && !bb_set |=> !bb)
    else $error("busy not cleared by stop");
  AST_BB_W1C: assert property ( // [R12]
    bb_clr && !bb_set |=> !bb)
    else $error("busy not cleared by write");
  AST_RESTART: assert property ( // [R13]
    wr_mode && hi_lane && regs.wr_data[`ISF_STT_BIT] && bb && !stop_det
      && !bb_clr && !prst |=> repeated_start)
    else $error("restart not signalled while busy");
  AST_W1C_ZERO: assert property ( // [R17]
    s_zero_write_bb ##0 (!stop_det && !prst) |=> bb)
    else $error("zero write cleared busy");
  AST_SET_WINS: assert property ( // [R18]
    nack_clr && nack_set |=> nack)
    else $error("clear beat hardware set");
  AST_SLAVE_TX_DIRECTION_FLAG_HOLD: assert property ( // [R3]
    !slave_tx_direction_flag && !slave_tx_active |=> !slave_tx_direction_flag)
    else $error("direction flag set without slave transmit");
  AST_SLAVE_TX_DIRECTION_FLAG_ZERO: assert property ( // [R17]
    slave_tx_direction_flag && wr_status && !regs.wr_data[`ISF_SLAVE_TX_DIRECTION_FLAG_BIT] && !start_det
      && !stop_det && !loopback_mode |=> slave_tx_direction_flag)
    else $error("zero write cleared direction flag");
  AST_NACK_ZERO: assert property ( // [R17]
    nack && wr_status && !regs.wr_data[`ISF_NACK_BIT] && !prst |=> nack)
    else $error("zero write cleared nack flag");
  AST_NACK_ONLY: assert property ( // [R6]
    !nack && !nack_set |=> !nack)
    else $error("nack flag set without nack");
  AST_NACK_HOLD: assert property ( // [R7]
    nack && !nack_clr && !prst |=> nack)
    else $error("nack flag lost");
  AST_BB_ONLY: assert property ( // [R9]
    !bb && !bb_set |=> !bb)
    else $error("busy set without start");
  AST_BB_HOLD: assert property ( // [R11]
    bb && !stop_det && !bb_clr && !prst |=> bb)
    else $error("busy lost");
  AST_BB_PRST: assert property ( // [R8]
    prst && !bb_set |=> !bb)
    else $error("busy survives peripheral reset");
  AST_STT_CLR: assert property ( // [R13]
    start_det && !(wr_mode && hi_lane && regs.wr_data[`ISF_STT_BIT])
      |=> !start_request)
    else $error("start request not cleared by start");
  AST_OVR_PRST: assert property ( // [R8]
    prst |=> !ovr)
    else $error("overrun survives peripheral reset");
  AST_OVR_READ: assert property ( // [R16]
    rd_rxdata && !rx_bit_valid |=> !ovr)
    else $error("overrun not cleared by read");
  AST_IRQ: assert property ( // [R6]
    nack && mask[`ISF_NACK_BIT] |-> irq)
    else $error("enabled flag without interrupt");
  AST_RUN_WR: assert property ( // [R8]
    wr_mode && lo_lane
      |=> peripheral_run == $past(regs.wr_data[`ISF_RUN_BIT]))
    else $error("run bit not written");
endmodule // isf_status_flags

/* src/isf_defs.svh */
`ifndef ISF_DEFS_SVH
`define ISF_DEFS_SVH
// Functional notes
// [R1] status bit 15 reads zero, writes ignored
// [R2] loopback mode forces slave direction flag low
// [R3] direction flag high only as slave-transmitter
// [R4] start or stop clears direction flag
// [R5] writing one clears direction flag
// [R6] receiver sending nack sets nack flag
// [R7] writing one to bit 13 clears nack
// [R8] run low or reset clears three flags
// [R9] start on bus sets busy flag
// [R10] clock low with run low sets busy
// [R11] stop on bus clears busy flag
// [R12] writing one to bit 12 clears busy
// [R13] start request while busy means restart
// [R14] new word before old read sets overrun
// [R15] overrun holds data, shift keeps overwriting
// [R16] reading receive data clears overrun
// [R17] writing zero leaves status bits unchanged
// [R18] hardware set beats software clear
`define ISF_OFS_MASK 6'h04
`define ISF_OFS_STATUS 6'h08
`define ISF_OFS_RXDATA 6'h18
`define ISF_OFS_MODE 6'h24
`define ISF_SLAVE_TX_DIRECTION_FLAG_BIT 14
`define ISF_NACK_BIT 13
`define ISF_BB_BIT 12
`define ISF_OVR_BIT 11
`define ISF_STT_BIT 13
`define ISF_RUN_BIT 5
`define ISF_DLB_BIT 3
`define ISF_MASK_RST 16'h0000
`define ISF_MODE_RST 16'h0000
`define ISF_FLAG_RST 1'b0
`endif

/* src/isf_pkg.sv */
package isf_pkg;
  typedef logic [15:0] isf_word_type;
  typedef enum logic [1:0] {
    ISF_OKAY = 2'b00,
    ISF_SLVERR = 2'b10
  } isf_resp_type;
  typedef enum logic {
    ISF_RD_IDLE = 1'b0,
    ISF_RD_RESP = 1'b1
  } isf_rd_state_type;
endpackage

/* src/isf_reg_if.sv */
`timescale 1ns/10ps
interface isf_reg_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_en;
  logic [5:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;
  modport bus(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input wr_err, rd_data, rd_err);
  modport core(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_err, rd_data, rd_err);
endinterface

/* src/isf_axil_slave.sv */
`timescale 1ns/10ps
module isf_axil_slave import isf_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  isf_reg_if.bus regs
);
  logic aw_full, w_full, next_aw_full, next_w_full, next_bvalid;
  logic [5:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data, next_rdata;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] next_bresp, next_rresp;
  isf_rd_state_type rd_state, next_rd_state;

  // address and data may arrive in either order; held until both are in
  assign awready = !aw_full && !bvalid;
  assign wready = !w_full && !bvalid;
  assign regs.wr_en = aw_full && w_full && !bvalid;
  assign regs.wr_addr = aw_addr;
  assign regs.wr_data = w_data;
  assign regs.wr_strb = w_strb;
  assign arready = (rd_state == ISF_RD_IDLE);
  assign regs.rd_en = arvalid && arready;
  assign regs.rd_addr = araddr;
  assign rvalid = (rd_state == ISF_RD_RESP);

  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rd_state = rd_state;
    next_rdata = rdata;
    next_rresp = rresp;
    if (awvalid && awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_full = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (regs.wr_en) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = regs.wr_err ? ISF_SLVERR : ISF_OKAY;
    end else if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    unique case (rd_state)
      ISF_RD_IDLE: begin
        if (arvalid) begin
          next_rd_state = ISF_RD_RESP;
          next_rdata = regs.rd_data;
          next_rresp = regs.rd_err ? ISF_SLVERR : ISF_OKAY;
        end
      end
      ISF_RD_RESP: begin
        if (rready) begin
          next_rd_state = ISF_RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= 6'h00;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rd_state <= ISF_RD_IDLE;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end else begin
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rd_state <= next_rd_state;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
endmodule // isf_axil_slave

/* src/isf_rx_path.sv */
`timescale 1ns/10ps
module isf_rx_path (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic bit_valid,
  input wire logic bit_in,
  input wire logic data_read,
  output logic [7:0] rx_data,
  output logic overrun
);
  logic [2:0] cnt, next_cnt;
  logic [7:0] shift, next_shift, next_rx_data, shifted;
  logic full, pend, next_full, next_pend, next_overrun, word_done;

  assign shifted = {shift[6:0], bit_in};
  assign word_done = bit_valid && (cnt == 3'h7);

  always_comb begin
    next_cnt = cnt;
    next_shift = shift;
    next_rx_data = rx_data;
    next_full = full;
    next_pend = pend;
    next_overrun = overrun;
    if (bit_valid) begin
      // bits keep landing in the shift register even during overrun
      next_shift = shifted; // [R15]
      next_cnt = cnt + 3'h1;
    end
    if (data_read) begin
      next_full = 1'b0;
      next_overrun = 1'b0; // [R16]
      if (pend) begin
        next_rx_data = shift;
        next_full = 1'b1;
        next_pend = 1'b0;
      end
    end
    if (word_done) begin
      if (full && !data_read) begin
        next_overrun = 1'b1; // [R14] [R18]
        next_pend = 1'b1;
      end else begin
        next_rx_data = shifted;
        next_full = 1'b1;
        next_pend = 1'b0;
      end
    end
    if (clear) begin
      next_cnt = 3'h0;
      next_full = 1'b0;
      next_pend = 1'b0;
      next_overrun = 1'b0; // [R8]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 3'h0;
      shift <= 8'h00;
      rx_data <= 8'h00;
      full <= 1'b0;
      pend <= 1'b0;
      overrun <= 1'b0;
    end else begin
      cnt <= next_cnt;
      shift <= next_shift;
      rx_data <= next_rx_data;
      full <= next_full;
      pend <= next_pend;
      overrun <= next_overrun;
    end
  end

  AST_OVR_SET: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
    word_done && full && !data_read && !clear |=> overrun)
    else $error("overrun not flagged");
  AST_OVR_HOLD: assert property (@(posedge aclk) disable iff (!aresetn) // [R15]
    overrun && !data_read && !clear |=> $stable(rx_data))
    else $error("receive data changed during overrun");
  AST_OVR_CLR: assert property (@(posedge aclk) disable iff (!aresetn) // [R16]
    data_read && !word_done |=> !overrun)
    else $error("overrun not cleared by read");
endmodule // isf_rx_path

/* dv/isf_bus_model.sv */
`timescale 1ns/10ps
// ****************************************
// far side of the bus: start, stop, nack, data bits
// ****************************************
module isf_bus_model (
  input wire logic aclk,
  output logic scl_in,
  output logic start_det,
  output logic stop_det,
  output logic nack_driven,
  output logic rx_bit_valid,
  output logic rx_bit
);
  initial begin
    scl_in = 1'b1;
    start_det = 1'b0;
    stop_det = 1'b0;
    nack_driven = 1'b0;
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
  end
  // pulses last one cycle, then one idle cycle
  task automatic pulse(input int kind);
    if (kind == 0) start_det <= 1'b1;
    else if (kind == 1) stop_det <= 1'b1;
    else nack_driven <= 1'b1;
    @(posedge aclk);
    start_det <= 1'b0;
    stop_det <= 1'b0;
    nack_driven <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic set_scl(input logic v);
    scl_in <= v;
    @(posedge aclk);
  endtask
  // msb first; data line shows the inverse once the bit is gone
  task automatic send_word(input logic [7:0] w);
    for (int i = 7; i >= 0; i--) begin
      scl_in <= 1'b0;
      @(posedge aclk);
      rx_bit <= w[i];
      rx_bit_valid <= 1'b1;
      @(posedge aclk);
      rx_bit_valid <= 1'b0;
      rx_bit <= ~w[i];
      scl_in <= 1'b1;
      @(posedge aclk);
    end
  endtask
endmodule // isf_bus_model

/* dv/testbench.sv */
`timescale 1ns/10ps
`include "isf_defs.svh"
module testbench import isf_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid;
  logic scl_in, start_det, stop_det, nack_driven, rx_bit_valid, rx_bit;
  logic slave_tx_active, receiver_mode;
  logic start_request, repeated_start, peripheral_run, loopback_mode, irq;
  int err_count, comparisons, cycles, m_stat, m_rx, m_shift, m_full;
  logic [7:0] lfsr;
  logic [31:0] rd_d, w1, w3;
  logic [1:0] rd_r;
  // ****************************************
  // design and far side
  // ****************************************
  isf_status_flags i_isf_status_flags (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .scl_in(scl_in), .start_det(start_det),
    .stop_det(stop_det), .slave_tx_active(slave_tx_active),
    .receiver_mode(receiver_mode), .nack_driven(nack_driven),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .start_request(start_request), .repeated_start(repeated_start),
    .peripheral_run(peripheral_run), .loopback_mode(loopback_mode),
    .irq(irq));
  isf_bus_model i_isf_bus_model (.aclk(aclk), .scl_in(scl_in),
    .start_det(start_det), .stop_det(stop_det),
    .nack_driven(nack_driven), .rx_bit_valid(rx_bit_valid),
    .rx_bit(rx_bit));
  // ****************************************
  // helpers
  // ****************************************
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // a hang anywhere ends here
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // ready is sampled at the falling edge: it cannot move before the rise
  task automatic axi_write(input logic [5:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [1:0] r);
    logic a_ok, w_ok, b_ok;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      a_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = bvalid;
      r = bresp;
      @(posedge aclk);
      if (a_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end while (!b_ok);
    // one idle edge, so the next call never re-drives in this step
    bready <= !b_ok;
    @(posedge aclk);
  endtask
  task automatic axi_read(input logic [5:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    logic a_ok, r_ok;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      a_ok = arvalid & arready;
      r_ok = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (a_ok) arvalid <= 1'b0;
    end while (!r_ok);
    rready <= !r_ok;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    axi_write(a, d, s, rd_r);
  endtask
  task automatic set_role(input logic tx, input logic rcv);
    slave_tx_active <= tx;
    receiver_mode <= rcv;
  endtask
  task automatic st_check();
    axi_read(`ISF_OFS_STATUS, rd_d, rd_r);
    check(rd_d, m_stat);
  endtask
  // reference receive path: one data word plus held shift word
  task automatic rx_word(input logic [7:0] w);
    i_isf_bus_model.send_word(w);
    if (m_full == 0) begin
      m_rx = w;
      m_full = 1;
    end else begin
      m_shift = w;
      m_stat |= 1 << `ISF_OVR_BIT;
    end
  endtask
  task automatic rx_read_check();
    axi_read(`ISF_OFS_RXDATA, rd_d, rd_r);
    check(rd_d, m_rx);
    if (m_stat & (1 << `ISF_OVR_BIT)) begin
      m_rx = m_shift;
      m_stat &= ~(1 << `ISF_OVR_BIT);
    end else m_full = 0;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr} = 12'h000;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    {slave_tx_active, receiver_mode} = 2'h0;
    {err_count, comparisons, cycles, m_stat, m_full} = '0;
    lfsr = 8'h43;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    st_check();
    axi_read(`ISF_OFS_MASK, rd_d, rd_r);
    check(rd_d, 32'h00000000);
    wr(`ISF_OFS_MODE, 32'h00000020);
    check({31'h0, peripheral_run}, 32'h1);
    i_isf_bus_model.pulse(0);
    m_stat |= 1 << `ISF_BB_BIT;
    set_role(1'b1, 1'b0);
    @(posedge aclk);
    m_stat |= 1 << `ISF_SLAVE_TX_DIRECTION_FLAG_BIT;
    st_check();
    wr(`ISF_OFS_STATUS, 32'h00008000);
    st_check();
    wr(`ISF_OFS_MODE, 32'h00002020);
    check({31'h0, repeated_start}, 32'h1);
    check({31'h0, start_request}, 32'h1);
    set_role(1'b0, 1'b0);
    wr(`ISF_OFS_STATUS, 1 << `ISF_SLAVE_TX_DIRECTION_FLAG_BIT);
    m_stat &= ~(1 << `ISF_SLAVE_TX_DIRECTION_FLAG_BIT);
    st_check();
    set_role(1'b1, 1'b0);
    @(posedge aclk);
    set_role(1'b0, 1'b0);
    i_isf_bus_model.pulse(0);
    check({31'h0, repeated_start}, 32'h0);
    check({31'h0, start_request}, 32'h0);
    st_check();
    set_role(1'b1, 1'b0);
    @(posedge aclk);
    set_role(1'b0, 1'b0);
    i_isf_bus_model.pulse(1);
    m_stat = 0;
    st_check();
    i_isf_bus_model.pulse(2);
    st_check();
    wr(`ISF_OFS_MASK, 1 << `ISF_NACK_BIT);
    set_role(1'b0, 1'b1);
    i_isf_bus_model.pulse(2);
    m_stat |= 1 << `ISF_NACK_BIT;
    check({31'h0, irq}, 32'h1);
    st_check();
    wr(`ISF_OFS_MASK, 32'h00000000);
    check({31'h0, irq}, 32'h0);
    wr(`ISF_OFS_STATUS, 1 << `ISF_NACK_BIT);
    m_stat = 0;
    st_check();
    i_isf_bus_model.pulse(0);
    m_stat |= 1 << `ISF_BB_BIT;
    wr(`ISF_OFS_STATUS, 1 << `ISF_BB_BIT, 4'h1);
    st_check();
    wr(`ISF_OFS_STATUS, 1 << `ISF_BB_BIT);
    m_stat = 0;
    st_check();
    repeat (3) begin
      lfsr = lfsr_next(lfsr);
      rx_word(lfsr);
      st_check();
    end
    rx_read_check();
    st_check();
    rx_read_check();
    wr(`ISF_OFS_MODE, 32'h00000028);
    check({31'h0, loopback_mode}, 32'h1);
    set_role(1'b1, 1'b1);
    repeat (2) @(posedge aclk);
    st_check();
    set_role(1'b0, 1'b1);
    i_isf_bus_model.pulse(2);
    i_isf_bus_model.pulse(0);
    m_stat = (1 << `ISF_NACK_BIT) | (1 << `ISF_BB_BIT);
    st_check();
    wr(`ISF_OFS_MODE, 32'h00000000);
    m_stat = 0;
    st_check();
    i_isf_bus_model.set_scl(1'b0);
    repeat (2) @(posedge aclk);
    m_stat = 1 << `ISF_BB_BIT;
    st_check();
    i_isf_bus_model.set_scl(1'b1);
    axi_write(6'h3c, 32'h0000ffff, 4'hf, rd_r);
    check({30'h0, rd_r}, {30'h0, ISF_SLVERR});
    axi_read(6'h3c, rd_d, rd_r);
    check(rd_d, 32'h00000000);
    check({30'h0, rd_r}, {30'h0, ISF_SLVERR});
    tally_and_finish();
  end
endmodule // testbench
